// [inc/strobe_ram_pkg.sv]
// constants, carriers and address decode helpers for the strobe-clocked 1k x 4 memory
`default_nettype none
package strobe_ram_pkg;

  // ----------------------------------------------------------------
  // organisation
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 4;
  localparam int WORDS     = 1024;
  localparam int ROW_BITS  = 6;
  localparam int ROWS      = 64;
  localparam int COL_BITS  = 4;
  localparam int ROW_WIDTH = 64;
  localparam int ROW_LSB   = 0;
  localparam int COL_LSB   = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int ACCESS_TIME_NS = 200;
  localparam int PRESET_TIME_NS = 100;
  localparam int DATA_SETUP_NS  = 100;
  // longest times round down, least times round up, never below one cycle
  localparam int ACCESS_CYC_RAW = ACCESS_TIME_NS / CLK_PERIOD_NS;
  localparam int PRESET_CYC_RAW = PRESET_TIME_NS / CLK_PERIOD_NS;
  localparam int SETUP_CYC_RAW  = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC     = (ACCESS_CYC_RAW < 1) ? 1 : ACCESS_CYC_RAW;
  localparam int PRESET_CYC     = (PRESET_CYC_RAW < 1) ? 1 : PRESET_CYC_RAW;
  localparam int SETUP_CYC      = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
  localparam int CNT_W          = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] OUT_RESET  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;
  localparam logic              SEL_N_RESET = 1'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_UNINIT = 3'h0,
    PH_READY  = 3'h1,
    PH_ACCESS = 3'h2,
    PH_VALID  = 3'h3,
    PH_PRESET = 3'h4
  } phase_type;

  typedef struct packed {
    logic              strobe;
    logic              write_n;
    logic              bank_sel_n;
    logic              out_en;
    logic              output_off_ctl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pin_in_type;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic [ROW_BITS-1:0] row_of(input logic [ADDR_W-1:0] a);
    return a[COL_LSB-1:ROW_LSB];
  endfunction : row_of

  function automatic logic [COL_BITS-1:0] col_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:COL_LSB];
  endfunction : col_of

endpackage : strobe_ram_pkg
`default_nettype wire

// [rtl/pin_sync.sv]
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync
`default_nettype wire

// [rtl/cell_array.sv]
// storage matrix: 64 rows of 64 cells, 4 of 64 columns picked per access
`timescale 1ns/1ps
`default_nettype none
module cell_array (
  input  wire logic                                mclk,
  input  wire logic [strobe_ram_pkg::ADDR_W-1:0]   addr,
  input  wire logic                                wr_en,
  input  wire logic [strobe_ram_pkg::DATA_W-1:0]   wr_data,
  output var  logic [strobe_ram_pkg::DATA_W-1:0]   rd_data_q
);

  logic [strobe_ram_pkg::ROW_WIDTH-1:0] rows_q [strobe_ram_pkg::ROWS];

  wire [strobe_ram_pkg::ROW_BITS-1:0] row_sel = strobe_ram_pkg::row_of(addr);
  wire [strobe_ram_pkg::ROW_BITS-1:0] col_pos = {strobe_ram_pkg::col_of(addr), 2'h0};

  // ----------------------------------------------------------------
  // write and sense
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      rows_q[row_sel][col_pos +: strobe_ram_pkg::DATA_W] <= wr_data;
    end
    rd_data_q <= rows_q[row_sel][col_pos +: strobe_ram_pkg::DATA_W];
  end

endmodule : cell_array
`default_nettype wire

// [rtl/edge_clocked_static_ram_1kx4.sv]
// strobe-clocked 1024 x 4 static memory with self-timed progress flag
//
// Behaviour
// - 1024 words of 4 bits, chosen by ten-bit address captured at cycle start.
// - low six address bits pick a row, upper four pick 4 of 64 columns.
// - strobe rise captures address; address pins ignored afterwards until next cycle.
// - bank select captured one cycle after the address and kept until the next cycle.
// - unselected chip keeps output buffer off and never writes.
// - write only while selected, strobe high, write line low; either ends it.
// - write line ignored while strobe low; the buffer gate does not decode it, but an active write sets avail_q.
// - a write stores data stable one set-up interval before it ended.
// - during an established write the output shows the data being written.
// - read data enters output register at access end, stable while strobe high.
// - strobe fall latches output data, held while strobe stays low.
// - output disabled while strobe low clears the output data register.
// - each strobe rise that starts a cycle clears the output latch and turns the buffer off.
// - buffer off if enable low or off-control high; on only when selected with data.
// - strobe fall starts preset; new cycle only after; flag low marks completion.
// - flag rises when read data is valid; host may then drop strobe.
// - flag runs as for a read in every cycle; host judges write completion.
// - flag always driven and unaffected by the output enable controls.
`timescale 1ns/1ps
`default_nettype none
module edge_clocked_static_ram_1kx4 #(
  parameter int ACCESS_CYCLES = strobe_ram_pkg::ACCESS_CYC,
  parameter int PRESET_CYCLES = strobe_ram_pkg::PRESET_CYC,
  parameter int SETUP_CYCLES  = strobe_ram_pkg::SETUP_CYC
) (
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  input  wire logic                              strobe,
  input  wire logic                              write_n,
  input  wire logic                              bank_sel_n,
  input  wire logic                              out_en,
  input  wire logic                              output_off_ctl,
  input  wire logic [strobe_ram_pkg::ADDR_W-1:0] addr,
  input  wire logic [strobe_ram_pkg::DATA_W-1:0] data_in,
  output var  logic [strobe_ram_pkg::DATA_W-1:0] data_out,
  output var  logic                              data_oe,
  output var  logic                              cycle_progress_flag
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  // all pins share one two-stage synchroniser so they keep their relative timing
  strobe_ram_pkg::pin_in_type pins_raw;
  strobe_ram_pkg::pin_in_type pins_s;
  logic [$bits(strobe_ram_pkg::pin_in_type)-1:0] pins_sync;

  assign pins_raw.strobe         = strobe;
  assign pins_raw.write_n        = write_n;
  assign pins_raw.bank_sel_n     = bank_sel_n;
  assign pins_raw.out_en         = out_en;
  assign pins_raw.output_off_ctl = output_off_ctl;
  assign pins_raw.addr           = addr;
  assign pins_raw.data           = data_in;

  pin_sync #(
    .WIDTH ($bits(strobe_ram_pkg::pin_in_type))
  ) u_pin_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign pins_s = strobe_ram_pkg::pin_in_type'(pins_sync);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  strobe_ram_pkg::phase_type                 phase_q;
  strobe_ram_pkg::phase_type                 phase_d;
  logic [strobe_ram_pkg::CNT_W-1:0]          cnt_q;
  logic [strobe_ram_pkg::CNT_W-1:0]          cnt_d;
  logic                                      strobe_q;
  logic [strobe_ram_pkg::ADDR_W-1:0]         addr_q;
  logic                                      sel_n_q;
  logic                                      sel_pend_q;
  logic [strobe_ram_pkg::DATA_W-1:0]         out_q;
  logic                                      avail_q;
  logic                                      write_q;
  logic                                      flag_q;
  logic [strobe_ram_pkg::DATA_W-1:0]         hist_q [SETUP_CYCLES];
  logic [strobe_ram_pkg::DATA_W-1:0]         rd_data;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire strobe_rise  = pins_s.strobe & ~strobe_q;
  wire strobe_fall  = ~pins_s.strobe & strobe_q;
  // a rise during preset is not a cycle: the array is not ready for it
  wire accept       = strobe_rise & (phase_q == strobe_ram_pkg::PH_READY);
  wire in_cycle     = (phase_q == strobe_ram_pkg::PH_ACCESS) | (phase_q == strobe_ram_pkg::PH_VALID);
  // bank select is taken one cycle after the rise, giving a late select some slack
  wire selected     = ~sel_n_q & ~sel_pend_q;
  wire out_enabled  = pins_s.out_en & ~pins_s.output_off_ctl;
  wire write_active = selected & pins_s.strobe & ~pins_s.write_n & in_cycle;
  wire write_end    = write_q & ~write_active;
  wire access_done  = (phase_q == strobe_ram_pkg::PH_ACCESS) & (cnt_q == '0) & pins_s.strobe;
  wire preset_done  = (phase_q == strobe_ram_pkg::PH_PRESET) & (cnt_q == '0);
  wire flag_d       = (phase_d == strobe_ram_pkg::PH_VALID) | (phase_d == strobe_ram_pkg::PH_PRESET);

  // ----------------------------------------------------------------
  // phase sequencing
  // ----------------------------------------------------------------
  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    case (phase_q)
      strobe_ram_pkg::PH_UNINIT: begin
        // nothing is valid until the host has held the strobe low once
        if (!pins_s.strobe) begin
          phase_d = strobe_ram_pkg::PH_PRESET;
          cnt_d   = strobe_ram_pkg::CNT_W'(PRESET_CYCLES - 1);
        end
      end
      strobe_ram_pkg::PH_READY: begin
        if (accept) begin
          phase_d = strobe_ram_pkg::PH_ACCESS;
          cnt_d   = strobe_ram_pkg::CNT_W'(ACCESS_CYCLES - 1);
        end
      end
      strobe_ram_pkg::PH_ACCESS: begin
        if (!pins_s.strobe) begin
          phase_d = strobe_ram_pkg::PH_PRESET;
          cnt_d   = strobe_ram_pkg::CNT_W'(PRESET_CYCLES - 1);
        end else if (cnt_q == '0) begin
          phase_d = strobe_ram_pkg::PH_VALID;
        end else begin
          cnt_d = cnt_q - 1'h1;
        end
      end
      strobe_ram_pkg::PH_VALID: begin
        if (!pins_s.strobe) begin
          phase_d = strobe_ram_pkg::PH_PRESET;
          cnt_d   = strobe_ram_pkg::CNT_W'(PRESET_CYCLES - 1);
        end
      end
      strobe_ram_pkg::PH_PRESET: begin
        // the preset runs to its end even if the strobe rises early
        if (cnt_q == '0) begin
          phase_d = strobe_ram_pkg::PH_READY;
        end else begin
          cnt_d = cnt_q - 1'h1;
        end
      end
      default: begin
        phase_d = strobe_ram_pkg::PH_UNINIT;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase_q  <= strobe_ram_pkg::PH_UNINIT;
      cnt_q    <= '0;
      strobe_q <= 1'h0;
      flag_q   <= 1'h0;
    end else begin
      phase_q  <= phase_d;
      cnt_q    <= cnt_d;
      strobe_q <= pins_s.strobe;
      flag_q   <= flag_d;
    end
  end

  // ----------------------------------------------------------------
  // address and bank select capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_q     <= strobe_ram_pkg::ADDR_RESET;
      sel_n_q    <= strobe_ram_pkg::SEL_N_RESET;
      sel_pend_q <= 1'h0;
    end else begin
      sel_pend_q <= accept;
      if (accept) begin
        addr_q <= pins_s.addr;
      end
      if (sel_pend_q) begin
        sel_n_q <= pins_s.bank_sel_n;
      end
    end
  end

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  // a short history of the data pins; the cell takes the oldest entry when the
  // write ends, so late changes inside the set-up window do not reach the cell
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      write_q <= 1'h0;
      for (int i = 0; i < SETUP_CYCLES; i++) begin
        hist_q[i] <= strobe_ram_pkg::OUT_RESET;
      end
    end else begin
      write_q   <= write_active;
      hist_q[0] <= pins_s.data;
      for (int i = 1; i < SETUP_CYCLES; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

  cell_array u_cell_array (
    .mclk      (mclk),
    .addr      (addr_q),
    .wr_en     (write_end),
    .wr_data   (hist_q[SETUP_CYCLES-1]),
    .rd_data_q (rd_data)
  );

  // ----------------------------------------------------------------
  // output data register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_q   <= strobe_ram_pkg::OUT_RESET;
      avail_q <= 1'h0;
    end else if (accept) begin
      out_q   <= strobe_ram_pkg::OUT_RESET;
      avail_q <= 1'h0;
    end else if (!pins_s.strobe && !out_enabled) begin
      out_q   <= strobe_ram_pkg::OUT_RESET;
      avail_q <= 1'h0;
    end else if (write_active) begin
      out_q   <= pins_s.data;
      avail_q <= 1'h1;
    end else if (access_done) begin
      out_q   <= rd_data;
      avail_q <= 1'h1;
    end
    // otherwise held: stable while the strobe stays high and latched while low
  end

  assign data_out = out_q;
  // the buffer gate decodes the synchronised enable and off-control pins by level, so those two controls act two clock cycles after the pins change
  assign data_oe  = selected & out_enabled & avail_q;
  assign cycle_progress_flag = flag_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int ACC_LIM = 300;
  localparam int PRE_LIM = 300;

  property p_oe_gate;
    @(posedge mclk) disable iff (sys_rst)
      data_oe |-> (pins_s.out_en && !pins_s.output_off_ctl && !sel_n_q && avail_q);
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("output buffer on without enable");

  property p_no_write_unselected;
    @(posedge mclk) disable iff (sys_rst)
      write_end |-> $past(!sel_n_q && pins_s.strobe && !pins_s.write_n);
  endproperty
  a_no_write_unselected: assert property (p_no_write_unselected) else $error("write without select");

  property p_write_needs_strobe;
    @(posedge mclk) disable iff (sys_rst)
      !pins_s.strobe |-> !write_active;
  endproperty
  a_write_needs_strobe: assert property (p_write_needs_strobe) else $error("write while strobe low");

  property p_rise_clears;
    @(posedge mclk) disable iff (sys_rst)
      accept |=> (out_q == strobe_ram_pkg::OUT_RESET) && !data_oe;
  endproperty
  a_rise_clears: assert property (p_rise_clears) else $error("output not cleared at cycle start");

  property p_disable_clears;
    @(posedge mclk) disable iff (sys_rst)
      (!pins_s.strobe && !out_enabled && !accept) |=> (out_q == strobe_ram_pkg::OUT_RESET) && !avail_q;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("output register not cleared");

  property p_low_holds;
    @(posedge mclk) disable iff (sys_rst)
      (!pins_s.strobe && out_enabled && !accept) |=> $stable(out_q);
  endproperty
  a_low_holds: assert property (p_low_holds) else $error("output changed while strobe low");

  property p_write_echo;
    @(posedge mclk) disable iff (sys_rst)
      (write_active && !accept) |=> (out_q == $past(pins_s.data, 1));
  endproperty
  a_write_echo: assert property (p_write_echo) else $error("output does not follow write data");

  property p_addr_only_at_accept;
    @(posedge mclk) disable iff (sys_rst)
      $changed(addr_q) |-> $past(accept);
  endproperty
  a_addr_only_at_accept: assert property (p_addr_only_at_accept) else $error("address moved mid cycle");

  property p_sel_only_after_accept;
    @(posedge mclk) disable iff (sys_rst)
      $changed(sel_n_q) |-> $past(accept, 2);
  endproperty
  a_sel_only_after_accept: assert property (p_sel_only_after_accept) else $error("select moved mid cycle");

  property p_access_bound;
    @(posedge mclk) disable iff (sys_rst)
      accept |-> ##[1:ACC_LIM] (cycle_progress_flag || !pins_s.strobe);
  endproperty
  a_access_bound: assert property (p_access_bound) else $error("access never completed");

  property p_flag_rise_at_valid;
    @(posedge mclk) disable iff (sys_rst)
      access_done |=> (phase_q == strobe_ram_pkg::PH_VALID) ##0 cycle_progress_flag;
  endproperty
  a_flag_rise_at_valid: assert property (p_flag_rise_at_valid) else $error("flag late at access end");

  property p_preset_bound;
    @(posedge mclk) disable iff (sys_rst)
      (strobe_fall && phase_q == strobe_ram_pkg::PH_VALID) |-> ##[1:PRE_LIM] !cycle_progress_flag;
  endproperty
  a_preset_bound: assert property (p_preset_bound) else $error("preset never completed");

  property p_flag_falls_after_preset;
    @(posedge mclk) disable iff (sys_rst)
      $fell(cycle_progress_flag) |-> $past(preset_done);
  endproperty
  a_flag_falls_after_preset: assert property (p_flag_falls_after_preset) else $error("flag fell early");

  property p_flag_ignores_oe;
    @(posedge mclk) disable iff (sys_rst)
      (phase_q == strobe_ram_pkg::PH_VALID) |-> cycle_progress_flag;
  endproperty
  a_flag_ignores_oe: assert property (p_flag_ignores_oe) else $error("flag dropped while valid");

  property p_read_stable_high;
    @(posedge mclk) disable iff (sys_rst)
      (phase_q == strobe_ram_pkg::PH_VALID && pins_s.strobe && !write_active && out_enabled) |=> $stable(out_q);
  endproperty
  a_read_stable_high: assert property (p_read_stable_high) else $error("read data moved");

endmodule : edge_clocked_static_ram_1kx4
`default_nettype wire

// [bench/strobe_host.sv]
// host-side model: drives strobe, address, select, write line and write data
`timescale 1ns/1ps
`default_nettype none
module strobe_host (
  input  wire logic                              mclk,
  input  wire logic                              flag,
  input  wire logic [strobe_ram_pkg::DATA_W-1:0] data_out,
  input  wire logic                              data_oe,
  output var  logic                              strobe,
  output var  logic                              write_n,
  output var  logic                              bank_sel_n,
  output var  logic [strobe_ram_pkg::ADDR_W-1:0] addr,
  output var  logic [strobe_ram_pkg::DATA_W-1:0] data_in
);
  // ----
  // power-on state
  // ----
  initial begin
    strobe     = 1'b0; // strobe low from power-on presets the memory
    write_n    = 1'b1;
    bank_sel_n = 1'b1;
    addr       = 10'h000;
    data_in    = 4'h0;
  end

  // ----
  // bounded wait on the flag; pre keeps the port value of the last edge before it
  // ----
  task automatic wait_flag(input logic lvl, output logic ok, output logic [4:0] pre);
    ok  = 1'b0;
    pre = 5'h00;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge mclk);
      #1;
      ok = (flag === lvl);
      if (!ok) pre = {data_oe, data_out};
    end
  endtask : wait_flag

  // ----
  // one full cycle
  // ----
  task automatic cycle(input logic wr, input logic sel_n, input logic [9:0] a, input logic [3:0] d,
                       input logic [3:0] d2, output logic [4:0] s_pre, output logic [4:0] s_up,
                       output logic [4:0] s_late, output logic [4:0] s_low, output logic ok);
    logic       ok1;
    logic [4:0] unused;
    @(posedge mclk);
    #1;
    addr    = a;
    write_n = ~wr; // steady from the rise, so the write lasts until the strobe fall
    data_in = d;
    strobe  = 1'b1;
    #4;
    bank_sel_n = sel_n; // select settles just after the strobe rise
    wait_flag(1'b1, ok1, s_pre); // strobe held high until access done
    s_up = {data_oe, data_out};
    // released address lines show the inverse, not the old value
    addr    = ~a;
    data_in = d2;
    repeat (5) @(posedge mclk);
    #1;
    s_late     = {data_oe, data_out};
    strobe     = 1'b0;
    bank_sel_n = ~sel_n;
    wait_flag(1'b0, ok, unused); // strobe low until preset done
    ok      = ok & ok1;
    s_low   = {data_oe, data_out};
    write_n = 1'b1;
    data_in = ~d2;
  endtask : cycle
endmodule : strobe_host
`default_nettype wire

// [bench/edge_clocked_static_ram_1kx4_tb_top.sv]
// self-checking bench for the strobe-clocked 1k x 4 memory
`timescale 1ns/1ps
`default_nettype none
module edge_clocked_static_ram_1kx4_tb_top;
  typedef struct packed {
    logic       wr;
    logic       sel_n;
    logic [9:0] a;
    logic [3:0] d;
    logic [3:0] d2;
    logic [3:0] e_up;
    logic [3:0] e_late;
  } row_type;

  logic       mclk           = 1'b0;
  logic       sys_rst        = 1'b1;
  logic       out_en         = 1'b1; // buffer enabled before each strobe fall of the row table
  logic       output_off_ctl = 1'b0;
  logic       strobe;
  logic       write_n;
  logic       bank_sel_n;
  logic [9:0] addr;
  logic [3:0] data_in;
  logic [3:0] data_out;
  logic       data_oe;
  logic       cycle_progress_flag;
  int         errors         = 0;
  int         n_checks       = 0;

  row_type rows [12] = '{
    '{1'b1, 1'b0, 10'h3FF, 4'hA, 4'hA, 4'hA, 4'hA}, // top word
    '{1'b1, 1'b0, 10'h000, 4'h5, 4'h5, 4'h5, 4'h5},
    '{1'b1, 1'b0, 10'h03F, 4'hC, 4'hC, 4'hC, 4'hC}, // last row, first column group
    '{1'b1, 1'b0, 10'h040, 4'h3, 4'h3, 4'h3, 4'h3},
    '{1'b1, 1'b1, 10'h3FF, 4'h6, 4'h6, 4'h0, 4'h0}, // unselected write dropped
    '{1'b1, 1'b0, 10'h155, 4'h9, 4'h6, 4'h9, 4'h6}, // data changed mid-write
    '{1'b0, 1'b1, 10'h3FF, 4'h0, 4'h0, 4'h0, 4'h0},
    '{1'b0, 1'b0, 10'h3FF, 4'h0, 4'h0, 4'hA, 4'hA},
    '{1'b0, 1'b0, 10'h000, 4'h0, 4'h0, 4'h5, 4'h5},
    '{1'b0, 1'b0, 10'h03F, 4'h0, 4'h0, 4'hC, 4'hC},
    '{1'b0, 1'b0, 10'h040, 4'h0, 4'h0, 4'h3, 4'h3},
    '{1'b0, 1'b0, 10'h155, 4'h0, 4'h0, 4'h6, 4'h6}
  };

  always #25 mclk = ~mclk;

  edge_clocked_static_ram_1kx4 u_edge_clocked_static_ram_1kx4 (
    .mclk                (mclk),
    .sys_rst             (sys_rst),
    .strobe              (strobe),
    .write_n             (write_n),
    .bank_sel_n          (bank_sel_n),
    .out_en              (out_en),
    .output_off_ctl      (output_off_ctl),
    .addr                (addr),
    .data_in             (data_in),
    .data_out            (data_out),
    .data_oe             (data_oe),
    .cycle_progress_flag (cycle_progress_flag)
  );

  strobe_host u_strobe_host (
    .mclk       (mclk),
    .flag       (cycle_progress_flag),
    .data_out   (data_out),
    .data_oe    (data_oe),
    .strobe     (strobe),
    .write_n    (write_n),
    .bank_sel_n (bank_sel_n),
    .addr       (addr),
    .data_in    (data_in)
  );

  // ----
  // compare and close
  // ----
  task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ----
  // sequence
  // ----
  initial begin
    logic [4:0] s_pre, s_up, s_late, s_low, m;
    logic       ok;
    repeat (10) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    check("rst", {data_oe, data_out}, 5'h00);
    u_strobe_host.wait_flag(1'b1, ok, s_pre);
    check("preset_up", {4'h0, ok}, 5'h01);
    u_strobe_host.wait_flag(1'b0, ok, s_pre);
    check("preset_dn", {4'h0, ok}, 5'h01);
    foreach (rows[i]) begin
      u_strobe_host.cycle(rows[i].wr, rows[i].sel_n, rows[i].a, rows[i].d, rows[i].d2, s_pre, s_up, s_late, s_low, ok);
      m = rows[i].sel_n ? 5'h10 : 5'h1F;
      check("ok", {4'h0, ok}, 5'h01);
      if (!rows[i].wr) check("pre", s_pre & m, 5'h00);
      check("up", s_up & m, {~rows[i].sel_n, rows[i].e_up} & m);
      check("late", s_late & m, {~rows[i].sel_n, rows[i].e_late} & m);
      check("low", s_low & m, {~rows[i].sel_n, rows[i].e_late} & m);
    end
    // ----
    // awkward cases
    // ----
    out_en = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    check("clr", {data_oe, data_out}, 5'h00);
    // both off controls: the flag must keep running while the buffer stays off
    for (int k = 0; k < 2; k++) begin
      out_en         = k[0];
      output_off_ctl = k[0];
      u_strobe_host.cycle(1'b0, 1'b0, 10'h000, 4'h0, 4'h0, s_pre, s_up, s_late, s_low, ok);
      check("flag", {4'h0, ok}, 5'h01);
      check("off", {3'h0, s_up[4], s_late[4]}, 5'h00);
    end
    out_en         = 1'b1;
    output_off_ctl = 1'b0;
    @(posedge mclk);
    #1;
    u_strobe_host.data_in = 4'hF;
    u_strobe_host.write_n = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    u_strobe_host.write_n = 1'b1;
    u_strobe_host.cycle(1'b0, 1'b0, 10'h000, 4'h0, 4'h0, s_pre, s_up, s_late, s_low, ok);
    check("nowr", s_up, 5'h15);
    // read-modify-write: write line drops only one edge after the flag rise, so read and write data never overlap
    fork
      u_strobe_host.cycle(1'b0, 1'b0, 10'h155, 4'h0, 4'h7, s_pre, s_up, s_late, s_low, ok);
      begin
        @(posedge cycle_progress_flag);
        @(posedge mclk);
        #1;
        u_strobe_host.write_n = 1'b0;
      end
    join
    check("rmw_rd", s_up, 5'h16);
    check("rmw_wr", s_late, 5'h17);
    u_strobe_host.cycle(1'b0, 1'b0, 10'h155, 4'h0, 4'h0, s_pre, s_up, s_late, s_low, ok);
    check("rmw_back", s_up, 5'h17);
    conclude();
  end

  // about 330 cycles expected; five thousand allowed before calling it a hang
  initial begin
    #250000;
    errors++;
    conclude();
  end
endmodule : edge_clocked_static_ram_1kx4_tb_top
`default_nettype wire
